// File: rtl/flash_dev.sv
`timescale 1ns/1ps
module flash_dev
  import flash_link_pkg::*;
#(
  parameter int XFR_CYC_P = XFR_CYC,
  parameter int BUF_BYTES = PAGE_BIG,
  parameter logic [7:0] MFR_ID = 8'h5A, // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'hA5C3, // Arbitrary value
  parameter logic [7:0] REG_FILL = 8'h00
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  flash_link_if.dev link,
  input wire logic page_256_strap,
  input wire logic cfg_page_256,
  input wire logic xfr_start,
  output logic xfr_busy,
  output logic xfr_done,
  output logic page_256,
  input wire logic buf_we,
  input wire logic [8:0] buf_addr,
  input wire logic [7:0] buf_wdata,
  output logic cmd_valid,
  output logic [7:0] cmd_op
);
  localparam int XW = $clog2(XFR_CYC_P + 1);

  // ==========================================
  // Shared buffer memory
  // ==========================================
  logic [7:0] buf_mem [BUF_BYTES]; // Data buffer

  // Written from user side, read by link side
  always_ff @(posedge ref_clk) begin
    if (buf_we) begin
      buf_mem[buf_addr] <= buf_wdata;
    end
  end

  // ==========================================
  // User side: page size and transfer timer
  // ==========================================
  logic pg256_r; // Current page size select
  logic strap_done_r; // Strap already taken
  logic [XW-1:0] xfr_cnt_r; // Remaining transfer cycles
  logic xfr_done_r; // Transfer end pulse

  // Strap caught after reset release, user may shrink page
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pg256_r <= PAGE_256_RST;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      pg256_r <= page_256_strap;
      strap_done_r <= 1'b1;
    end else if (cfg_page_256) begin
      pg256_r <= 1'b1;
    end
  end

  // Page to buffer transfer busy window
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      xfr_cnt_r <= '0;
      xfr_done_r <= 1'b0;
    end else begin
      xfr_done_r <= (xfr_cnt_r == XW'(1));
      if (xfr_start && xfr_cnt_r == '0) begin
        xfr_cnt_r <= XW'(XFR_CYC_P);
      end else if (xfr_cnt_r != '0) begin
        xfr_cnt_r <= xfr_cnt_r - XW'(1);
      end
    end
  end

  assign xfr_busy = (xfr_cnt_r != '0);
  assign xfr_done = xfr_done_r;
  assign page_256 = pg256_r;

  // ==========================================
  // Link side: input shifting and decode
  // ==========================================
  logic frame_rst_n; // Low while deselected or reset
  logic busy_s; // Busy seen on link clock
  logic pg256_s; // Page size seen on link clock
  logic [2:0] bit_cnt_r; // Bit within byte
  logic [3:0] byte_cnt_r; // Header byte index
  logic [7:0] rx_sr_r; // Partial input byte
  logic [7:0] rx_nxt; // Byte including current bit
  logic [7:0] op_r; // Frame opcode
  logic [7:0] op_nxt; // Opcode as seen this edge
  logic [23:0] addr_r; // Address bytes
  logic [23:0] addr_src; // Address incl. last byte
  logic data_r; // Output phase active
  logic [8:0] ptr_r; // Buffer byte pointer
  logic [8:0] ptr_start; // Pointer at data start
  logic [8:0] page_last; // Last byte of a page
  logic [1:0] id_idx_r; // Identification byte index
  logic [7:0] cur_byte; // Byte being sent
  logic so_r; // Output bit
  logic so_oe_r; // Output enable
  logic cmd_tgl_r; // Toggles per opcode
  logic [7:0] op_hold_r; // Last opcode, stays past frame

  // Idle select holds the whole frame state in reset
  assign frame_rst_n = link.dev_rst_n & ~link.cs_n;

  // Bring user-side levels onto the link clock
  sig_sync #(
    .W(2)
  ) u_link_sync (
    .clk(link.sclk),
    .rst_n(link.dev_rst_n),
    .d({xfr_busy, pg256_r}),
    .q({busy_s, pg256_s})
  );

  // Incoming bit appended at the low end
  assign rx_nxt = {rx_sr_r[6:0], link.mosi};
  assign op_nxt = (byte_cnt_r == 4'h0) ? rx_nxt : op_r;
  assign addr_src = (byte_cnt_r == 4'h3) ? {addr_r[15:0], rx_nxt} : addr_r;
  assign page_last = pg256_s ? PAGE_SMALL_LAST : PAGE_BIG_LAST;
  assign ptr_start = pg256_s ? {1'b0, addr_src[7:0]} : addr_src[8:0];

  // Rising edge: take bits, count header, step pointer
  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 4'h0;
      rx_sr_r <= 8'h00;
      op_r <= 8'h00;
      addr_r <= 24'h000000;
      data_r <= 1'b0;
      ptr_r <= 9'h000;
      id_idx_r <= 2'h0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (!data_r) begin
        // Header phase
        rx_sr_r <= rx_nxt;
        if (bit_cnt_r == 3'h7) begin
          byte_cnt_r <= byte_cnt_r + 4'h1;
          if (byte_cnt_r == 4'h0) begin
            op_r <= rx_nxt;
          end else if (byte_cnt_r < 4'h4) begin
            addr_r <= {addr_r[15:0], rx_nxt};
          end
          // Known opcode with full header starts output
          if (hdr_bytes(op_nxt) != 4'h0 && hdr_bytes(op_nxt) == byte_cnt_r + 4'h1) begin
            data_r <= 1'b1;
            ptr_r <= ptr_start;
          end
        end
      end else if (bit_cnt_r == 3'h7) begin
        // Output byte done, advance within page
        ptr_r <= (ptr_r == page_last) ? 9'h000 : ptr_r + 9'h001;
        if (id_idx_r != 2'h3) begin
          id_idx_r <= id_idx_r + 2'h1;
        end
      end
    end
  end

  // Byte to send for the decoded opcode
  always_comb begin
    cur_byte = REG_FILL;
    case (op_r)
      // Array and buffer reads stream buffer bytes
      OP_RD_LEGACY, OP_RD_FAST, OP_RD_SLOW: cur_byte = buf_mem[ptr_r];
      OP_BUF_RD: cur_byte = buf_mem[ptr_r];
      // Protection, lockdown, security contents
      OP_PROT_RD, OP_LOCK_RD, OP_SEC_RD: cur_byte = REG_FILL;
      // Ready flag and page size flag
      OP_STAT_RD: cur_byte = {~busy_s, 6'h00, pg256_s};
      OP_ID_RD: begin
        // Maker then two device bytes
        case (id_idx_r)
          2'h0: cur_byte = MFR_ID;
          2'h1: cur_byte = DEV_ID[15:8];
          2'h2: cur_byte = DEV_ID[7:0];
          default: cur_byte = 8'h00;
        endcase
      end
      default: cur_byte = REG_FILL;
    endcase
  end

  // ==========================================
  // Link side: output driving
  // ==========================================
  // Falling edge: drive next bit, MSB first; valid in low phase
  always_ff @(negedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end else begin
      so_r <= cur_byte[3'h7 - bit_cnt_r];
      so_oe_r <= data_r;
    end
  end

  assign link.miso = so_r;
  assign link.miso_oe = so_oe_r;

  // ==========================================
  // Opcode report to user side
  // ==========================================
  // Toggle per received opcode, held across frames
  always_ff @(posedge link.sclk or negedge link.dev_rst_n) begin
    if (!link.dev_rst_n) begin
      cmd_tgl_r <= 1'b0;
      op_hold_r <= 8'h00;
    end else if (!link.cs_n && !data_r && bit_cnt_r == 3'h7 && byte_cnt_r == 4'h0) begin
      cmd_tgl_r <= ~cmd_tgl_r;
      op_hold_r <= rx_nxt;
    end
  end

  logic cmd_tgl_s; // Synchronised toggle
  logic cmd_tgl_d_r; // Previous synchronised toggle
  logic cmd_valid_r; // Opcode report pulse
  logic [7:0] cmd_op_r; // Reported opcode

  sig_sync #(
    .W(1)
  ) u_cmd_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(cmd_tgl_r),
    .q(cmd_tgl_s)
  );

  // Edge of toggle marks a new opcode; word is long stable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_tgl_d_r <= 1'b0;
      cmd_valid_r <= 1'b0;
      cmd_op_r <= 8'h00;
    end else begin
      cmd_tgl_d_r <= cmd_tgl_s;
      cmd_valid_r <= cmd_tgl_s ^ cmd_tgl_d_r;
      if (cmd_tgl_s ^ cmd_tgl_d_r) begin
        cmd_op_r <= op_hold_r;
      end
    end
  end

  assign cmd_valid = cmd_valid_r;
  assign cmd_op = cmd_op_r;
endmodule

// File: rtl/flash_host.sv
`timescale 1ns/1ps
// ==========================================
// Host end: makes link clock, runs frames
// ==========================================
module flash_host
  import flash_link_pkg::*;
#(
  parameter int RST_CYC_P = RST_PULSE_CYC,
  parameter int SECTOR_PAGES_P = SECTOR_PAGES,
  parameter int PAGE_AW = 9
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  flash_link_if.host link,
  input wire logic mode3,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_op,
  input wire logic [23:0] req_addr,
  input wire logic [15:0] req_len,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  input wire logic pe_done,
  input wire logic rw_ack,
  output logic rw_due,
  output logic [PAGE_AW-1:0] rw_page
);
  localparam int RW_EVERY = RW_LIMIT / SECTOR_PAGES_P;

  typedef enum logic [2:0] {ST_RST, ST_REC, ST_IDLE, ST_SHIFT, ST_PARK, ST_GAP} host_st_t;

  host_st_t st_r; // Frame sequencer
  logic [11:0] wait_r; // Wait counter
  logic [2:0] half_r; // Half period in cycles
  logic [2:0] hcnt_r; // Half period counter
  logic [19:0] rise_r; // Rising edges so far
  logic [19:0] nbits_r; // Total bits in frame
  logic [6:0] hbits_r; // Header bits
  logic mode3_r; // Idle clock high
  logic sclk_r; // Link clock
  logic cs_n_r; // Select
  logic dev_rst_n_r; // Device reset
  logic done_r; // Frame end pulse
  logic tick; // Half period elapsed
  logic rise_ev; // Clock goes high now
  logic fall_ev; // Clock goes low now

  assign tick = (hcnt_r == half_r - 3'h1);
  assign rise_ev = (st_r == ST_SHIFT) && tick && !sclk_r;
  assign fall_ev = (st_r == ST_SHIFT) && tick && sclk_r;
  assign req_ready = (st_r == ST_IDLE);

  // ==========================================
  // Sequencer and clock divider
  // ==========================================
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RST;
      wait_r <= 12'h000;
      half_r <= 3'(HALF_FAST_CYC);
      hcnt_r <= 3'h0;
      rise_r <= 20'h00000;
      nbits_r <= 20'h00000;
      hbits_r <= 7'h00;
      mode3_r <= 1'b0;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      dev_rst_n_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        ST_RST: begin
          // Select stays high while reset is held
          wait_r <= wait_r + 12'h001;
          if (wait_r == 12'(RST_CYC_P - 1)) begin
            dev_rst_n_r <= 1'b1;
            wait_r <= 12'h000;
            st_r <= ST_REC;
          end
        end
        ST_REC: begin
          wait_r <= wait_r + 12'h001;
          if (wait_r == 12'(RST_REC_CYC - 1)) begin
            st_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          // Clock rests at the chosen idle level
          sclk_r <= mode3;
          if (req_valid) begin
            mode3_r <= mode3;
            cs_n_r <= 1'b0;
            hcnt_r <= 3'h0;
            rise_r <= 20'h00000;
            hbits_r <= {hdr_bytes(req_op), 3'h0};
            nbits_r <= {1'b0, req_len, 3'h0} + {13'h0000, hdr_bytes(req_op), 3'h0};
            // Slow read and buffer read opcodes get the slower clock
            if (req_op == OP_RD_SLOW || req_op == OP_BUF_RD) begin
              half_r <= 3'(HALF_SLOW_CYC);
            end else begin
              half_r <= 3'(HALF_FAST_CYC);
            end
            st_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          hcnt_r <= tick ? 3'h0 : hcnt_r + 3'h1;
          if (tick) begin
            sclk_r <= ~sclk_r;
          end
          if (rise_ev) begin
            rise_r <= rise_r + 20'h00001;
          end
          // Last capture falling edge ends the frame
          if (fall_ev && rise_r == nbits_r) begin
            st_r <= mode3_r ? ST_PARK : ST_GAP;
            cs_n_r <= ~mode3_r;
            done_r <= ~mode3_r;
            wait_r <= 12'h000;
          end
        end
        ST_PARK: begin
          // Return clock high in the same cycle as deselect
          hcnt_r <= tick ? 3'h0 : hcnt_r + 3'h1;
          if (tick) begin
            sclk_r <= 1'b1;
            cs_n_r <= 1'b1;
            done_r <= 1'b1;
            st_r <= ST_GAP;
          end
        end
        ST_GAP: begin
          // Least select high time
          wait_r <= wait_r + 12'h001;
          if (wait_r == 12'(CS_HIGH_CYC - 1)) begin
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Transmit: launch after each rising edge
  // ==========================================
  logic [63:0] tx_sr_r; // Header shifter, MSB on line
  logic launch_r; // Rising edge seen last cycle

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sr_r <= 64'h0000000000000000;
      launch_r <= 1'b0;
    end else begin
      launch_r <= rise_ev;
      if (st_r == ST_IDLE && req_valid) begin
        tx_sr_r <= {req_op, req_addr, 32'h00000000};
      end else if (launch_r) begin
        tx_sr_r <= {tx_sr_r[62:0], 1'b0};
      end
    end
  end

  // ==========================================
  // Receive: capture at the next falling edge
  // ==========================================
  logic miso_s; // Synchronised device data
  logic [7:0] rx_sr_r; // Partial byte
  logic [2:0] rxn_r; // Bits in partial byte
  logic rd_valid_r; // Byte pulse
  logic [7:0] rd_data_r; // Received byte

  sig_sync #(
    .W(1)
  ) u_miso_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(link.miso_line),
    .q(miso_s)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sr_r <= 8'h00;
      rxn_r <= 3'h0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      rd_valid_r <= 1'b0;
      if (st_r == ST_IDLE) begin
        rxn_r <= 3'h0;
      end else if (fall_ev && rise_r > {13'h0000, hbits_r}) begin
        rx_sr_r <= {rx_sr_r[6:0], miso_s};
        rxn_r <= rxn_r + 3'h1;
        if (rxn_r == 3'h7) begin
          rd_valid_r <= 1'b1;
          rd_data_r <= {rx_sr_r[6:0], miso_s};
        end
      end
    end
  end

  // ==========================================
  // Page rewrite pointer upkeep
  // ==========================================
  logic [15:0] rw_cnt_r; // Ops since last due
  logic rw_due_r; // Rewrite owed
  logic [PAGE_AW-1:0] rw_page_r; // Next page to refresh
  logic rw_set; // Interval reached

  // Each page of a sector refreshed just inside the limit, every 78 ops (9984 per sector)
  assign rw_set = pe_done && (rw_cnt_r == 16'(RW_EVERY - 1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rw_cnt_r <= 16'h0000;
      rw_due_r <= 1'b0;
      rw_page_r <= '0;
    end else begin
      if (pe_done) begin
        rw_cnt_r <= rw_set ? 16'h0000 : rw_cnt_r + 16'h0001;
      end
      // Set wins over acknowledge
      rw_due_r <= rw_set | (rw_due_r & ~rw_ack);
      if (rw_ack && rw_due_r) begin
        rw_page_r <= rw_page_r + PAGE_AW'(1);
      end
    end
  end

  assign rw_due = rw_due_r;
  assign rw_page = rw_page_r;
  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.mosi = tx_sr_r[63];
  assign link.dev_rst_n = dev_rst_n_r;
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  assign done = done_r;
endmodule

// File: rtl/flash_link_if.sv
`timescale 1ns/1ps
// ==========================================
// Serial link between host and flash
// ==========================================
interface flash_link_if;
  logic cs_n; // Select, low active
  logic sclk; // Link clock from host
  logic mosi; // Host to device data
  logic miso; // Device data
  logic miso_oe; // Device drives miso
  logic dev_rst_n; // Device reset, low active
  wire miso_line; // Resolved output wire
  // Released line idles high, as through a pull-up
  assign miso_line = miso_oe ? miso : 1'b1;
  modport dev(input cs_n, input sclk, input mosi, input dev_rst_n, output miso, output miso_oe);
  modport host(output cs_n, output sclk, output mosi, output dev_rst_n, input miso_line);
endinterface

// File: rtl/flash_link_pkg.sv
// ==========================================
// Shared constants for both link ends
// ==========================================
package flash_link_pkg;
  // Read and register-read opcodes
  localparam logic [7:0] OP_RD_LEGACY = 8'hE8;
  localparam logic [7:0] OP_RD_FAST = 8'h0B;
  localparam logic [7:0] OP_RD_SLOW = 8'h03;
  localparam logic [7:0] OP_BUF_RD = 8'hD1;
  localparam logic [7:0] OP_PROT_RD = 8'h32;
  localparam logic [7:0] OP_LOCK_RD = 8'h35;
  localparam logic [7:0] OP_SEC_RD = 8'h77;
  localparam logic [7:0] OP_STAT_RD = 8'hD7;
  localparam logic [7:0] OP_ID_RD = 8'h9F;

  // Page geometry
  localparam int PAGE_BIG = 264;
  localparam int PAGE_SMALL = 256;
  localparam logic [8:0] PAGE_BIG_LAST = 9'h107;
  localparam logic [8:0] PAGE_SMALL_LAST = 9'h0FF;
  localparam logic PAGE_256_RST = 1'b0;

  // Timing in its own units, then in ref_clk cycles
  localparam int CLK_NS = 4;
  localparam int F_FAST_MHZ = 66;
  localparam int F_SLOW_MHZ = 33;
  localparam int HALF_FAST_CYC = (1000 + 2 * F_FAST_MHZ * CLK_NS - 1) / (2 * F_FAST_MHZ * CLK_NS);
  localparam int HALF_SLOW_CYC = (1000 + 2 * F_SLOW_MHZ * CLK_NS - 1) / (2 * F_SLOW_MHZ * CLK_NS);
  localparam int CS_HIGH_NS = 50;
  localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_PULSE_US = 10;
  localparam int RST_PULSE_CYC = (RST_PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int RST_REC_US = 1;
  localparam int RST_REC_CYC = (RST_REC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int XFR_US = 200;
  localparam int XFR_CYC = XFR_US * 1000 / CLK_NS;

  // Page rewrite maintenance
  localparam int RW_LIMIT = 10000;
  localparam int SECTOR_PAGES = 128;

  // Header bytes (opcode, address, dummy) before data flows
  function automatic logic [3:0] hdr_bytes(input logic [7:0] op);
    case (op)
      OP_RD_LEGACY: hdr_bytes = 4'h8;
      OP_RD_FAST: hdr_bytes = 4'h5;
      OP_RD_SLOW, OP_BUF_RD: hdr_bytes = 4'h4;
      OP_PROT_RD, OP_LOCK_RD, OP_SEC_RD: hdr_bytes = 4'h4;
      OP_STAT_RD, OP_ID_RD: hdr_bytes = 4'h1;
      default: hdr_bytes = 4'h0;
    endcase
  endfunction
endpackage

// File: rtl/sig_sync.sv
`timescale 1ns/1ps
// ==========================================
// Two-flop level synchroniser
// ==========================================
module sig_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r; // First stage, read only by q

  // Two stages on the destination clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// File: test/flash_link_checker_assertions.sv
`timescale 1ns/1ps
// ==========================================
// Link checks sampled on the user clock
// ==========================================
module flash_link_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic dev_rst_n
);
  // One domain: the link clock is divided from ref_clk
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Assertions
  // ==========================================
  a_idle_out_off: assert property (cs_n |-> !miso_oe)
    else $error("output driven while deselected");
  a_miso_on_fall: assert property (miso_oe && $changed(miso) |-> $fell(sclk))
    else $error("output bit moved off a falling edge");
  a_out_in_low: assert property (miso_oe && $changed(miso) |-> !sclk)
    else $error("output bit moved outside low phase");
  a_mosi_at_rise: assert property ($rose(sclk) && !cs_n |-> $stable(mosi))
    else $error("host data moved at a sampling edge");
  a_sel_clk_still: assert property ($fell(cs_n) |-> $stable(sclk))
    else $error("link clock moved as select fell");
  a_oe_on_fall: assert property ($rose(miso_oe) |-> $fell(sclk))
    else $error("first output bit not on a falling edge");
  a_high_phase: assert property ($rose(sclk) |=> sclk)
    else $error("clock high phase under two cycles");
  a_low_phase: assert property ($fell(sclk) |=> !sclk)
    else $error("clock low phase under two cycles");
  a_sel_over_rst: assert property (!dev_rst_n |-> cs_n)
    else $error("select active while device in reset");
  // Main scenarios reached
  c_frame: cover property ($fell(cs_n));
  c_output: cover property ($rose(miso_oe));
  c_dev_up: cover property ($rose(dev_rst_n));
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
// ==========================================
// Both link ends joined, user sides driven
// ==========================================
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  $display("BAD %s exp %h got %h", nm, ex, got); error_cnt++; end end
module tb_top;
  import flash_link_pkg::*;
  localparam int XFR_SIM = 400; // Short transfer window for simulation
  // Table row: request and the bytes it returns
  typedef struct {logic [7:0] op; logic [23:0] addr; int len; logic m3; logic [23:0] ex;} row_t;
  logic ref_clk = 1'b0; // User clock
  logic rst_n = 1'b0; // User reset
  logic mode3 = 1'b0, req_valid = 1'b0, pe_done = 1'b0, rw_ack = 1'b0;
  logic [7:0] req_op = 8'h00;
  logic [23:0] req_addr = 24'h000000;
  logic [15:0] req_len = 16'h0000;
  logic strap = 1'b0, cfg_256 = 1'b0, xfr_start = 1'b0, buf_we = 1'b0;
  logic [8:0] buf_addr = 9'h000;
  logic [7:0] buf_wdata = 8'h00;
  logic req_ready, rd_valid, done, rw_due, xfr_busy, xfr_done, page_256, cmd_valid;
  logic [7:0] rd_data, cmd_op;
  logic [8:0] rw_page;
  int error_cnt = 0, check_count = 0, n, t, cv;
  row_t rows[10];
  flash_link_if link_if();
  // ==========================================
  // Clock and instances
  // ==========================================
  always #2 ref_clk = ~ref_clk;
  flash_host #(.RST_CYC_P(20)) flash_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link_if),
    .mode3(mode3), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_len(req_len), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .pe_done(pe_done),
    .rw_ack(rw_ack), .rw_due(rw_due), .rw_page(rw_page));
  flash_dev #(.XFR_CYC_P(XFR_SIM)) flash_dev_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link_if),
    .page_256_strap(strap), .cfg_page_256(cfg_256), .xfr_start(xfr_start), .xfr_busy(xfr_busy),
    .xfr_done(xfr_done), .page_256(page_256), .buf_we(buf_we), .buf_addr(buf_addr),
    .buf_wdata(buf_wdata), .cmd_valid(cmd_valid), .cmd_op(cmd_op));
  flash_link_checker chk_inst (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(link_if.cs_n),
    .sclk(link_if.sclk), .mosi(link_if.mosi), .miso(link_if.miso), .miso_oe(link_if.miso_oe),
    .dev_rst_n(link_if.dev_rst_n));
  // ==========================================
  // Tasks
  // ==========================================
  // Verdict and end of run
  task final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One read frame, bytes compared as they arrive
  task frame(input row_t r);
    @(posedge ref_clk) mode3 <= r.m3;
    repeat (4) @(posedge ref_clk);
    req_op <= r.op;
    req_addr <= r.addr;
    req_len <= 16'(r.len);
    req_valid <= 1'b1;
    for (t = 0; t < 100 && req_ready !== 1'b1; t++) @(posedge ref_clk);
    @(posedge ref_clk) req_valid <= 1'b0;
    n = 0;
    cv = 0;
    for (t = 0; t < 3000 && done !== 1'b1; t++) begin
      @(posedge ref_clk);
      if (cmd_valid === 1'b1) cv++;
      if (rd_valid === 1'b1) begin
        `CHK("rd_data", r.ex[23 - 8 * n -: 8], rd_data)
        n++;
      end
    end
    `CHK("byte count", r.len, n)
    `CHK("cmd_op", r.op, cmd_op)
    `CHK("cmd_valid", 1, cv)
    repeat (16) @(posedge ref_clk);
    $display("frame %h done", r.op);
  endtask
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    rows = '{'{OP_RD_LEGACY, 24'h10, 2, 1'b0, 24'h2C2D00}, '{OP_RD_FAST, 24'h107, 2, 1'b1, 24'h3B3C00},
      '{OP_RD_SLOW, 24'h5, 1, 1'b0, 24'h390000}, '{OP_BUF_RD, 24'h20, 1, 1'b1, 24'h1C0000},
      '{OP_PROT_RD, 24'h0, 1, 1'b0, 24'h0}, '{OP_LOCK_RD, 24'h0, 1, 1'b1, 24'h0},
      '{OP_SEC_RD, 24'h0, 1, 1'b0, 24'h0}, '{OP_STAT_RD, 24'h0, 1, 1'b1, 24'h800000},
      '{OP_ID_RD, 24'h0, 3, 1'b0, 24'h5AA5C3}, '{OP_ID_RD, 24'h0, 1, 1'b1, 24'h5A0000}};
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    `CHK("cs_n idle", 1'b1, link_if.cs_n)
    `CHK("miso off", 1'b1, link_if.miso_line)
    `CHK("page_256", 1'b0, page_256)
    $display("reset test done");
    // Buffer pattern: byte i holds i ^ 3C
    for (int i = 0; i < PAGE_BIG; i++) begin
      @(posedge ref_clk) buf_we <= 1'b1;
      buf_addr <= 9'(i);
      buf_wdata <= 8'(i) ^ 8'h3C;
    end
    @(posedge ref_clk) buf_we <= 1'b0;
    for (t = 0; t < 1000 && req_ready !== 1'b1; t++) @(posedge ref_clk);
    foreach (rows[i]) frame(rows[i]);
    // Switch to 256-byte pages: wrap at 255, status bit 0 set
    @(posedge ref_clk) cfg_256 <= 1'b1;
    @(posedge ref_clk) cfg_256 <= 1'b0;
    @(posedge ref_clk);
    `CHK("page_256 set", 1'b1, page_256)
    frame('{OP_RD_FAST, 24'hFF, 2, 1'b0, 24'hC33C00});
    frame('{OP_STAT_RD, 24'h0, 1, 1'b0, 24'h810000});
    // Page to buffer transfer window
    @(posedge ref_clk) xfr_start <= 1'b1;
    @(posedge ref_clk) xfr_start <= 1'b0;
    @(posedge ref_clk);
    for (n = 0; n < 1000 && xfr_busy === 1'b1; n++) @(posedge ref_clk);
    `CHK("busy cycles", XFR_SIM, n)
    `CHK("xfr_done", 1'b1, xfr_done)
    // Status shows not ready while a transfer runs
    @(posedge ref_clk) xfr_start <= 1'b1;
    @(posedge ref_clk) xfr_start <= 1'b0;
    frame('{OP_STAT_RD, 24'h0, 1, 1'b0, 24'h010000});
    for (n = 0; n < 1000 && xfr_busy === 1'b1; n++) @(posedge ref_clk);
    `CHK("xfr_done 2", 1'b1, xfr_done)
    $display("transfer test done");
    // Rewrite pointer after one sector share of operations
    for (int i = 0; i < RW_LIMIT / SECTOR_PAGES; i++) begin
      @(posedge ref_clk) pe_done <= 1'b1;
      @(posedge ref_clk) pe_done <= 1'b0;
    end
    repeat (2) @(posedge ref_clk);
    `CHK("rw_due", 1'b1, rw_due)
    `CHK("rw_page", 9'h000, rw_page)
    @(posedge ref_clk) rw_ack <= 1'b1;
    @(posedge ref_clk) rw_ack <= 1'b0;
    @(posedge ref_clk);
    `CHK("rw_due clr", 1'b0, rw_due)
    `CHK("rw_page inc", 9'h001, rw_page)
    // Interval ends as an acknowledge arrives: set wins
    for (int i = 0; i < RW_LIMIT / SECTOR_PAGES; i++) begin
      @(posedge ref_clk) pe_done <= 1'b1;
      rw_ack <= (i == RW_LIMIT / SECTOR_PAGES - 1);
      @(posedge ref_clk) pe_done <= 1'b0;
      rw_ack <= 1'b0;
    end
    @(posedge ref_clk);
    `CHK("rw_due set wins", 1'b1, rw_due)
    `CHK("rw_page held", 9'h001, rw_page)
    $display("rewrite test done");
    // Second reset mid-run, strap now high
    @(posedge ref_clk) rst_n <= 1'b0;
    strap <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    `CHK("page_256 rst", 1'b0, page_256)
    `CHK("rw_page rst", 9'h000, rw_page)
    @(posedge ref_clk);
    `CHK("page_256 strap", 1'b1, page_256)
    for (t = 0; t < 1000 && req_ready !== 1'b1; t++) @(posedge ref_clk);
    frame('{OP_STAT_RD, 24'h0, 1, 1'b0, 24'h810000});
    $display("second reset test done");
    final_report();
  end
  // Hang guard, well beyond the expected run
  initial begin
    #120000;
    error_cnt++;
    final_report();
  end
endmodule
